// ---- pkg/pmurb_pkg.sv ----
package pmurb_pkg;

	// ----------------------------------------
	// Command layout
	// ----------------------------------------
	localparam int CMD_W        = 29;
	localparam int DATA_W       = 24;
	localparam int PAD_W        = 5;
	localparam int POS_RW       = 28;
	localparam int POS_CH_HI    = 27;
	localparam int POS_CH_LO    = 24;
	localparam int POS_TYPE_HI  = 23;
	localparam int POS_TYPE_LO  = 22;
	localparam int POS_ADDR_HI  = 21;
	localparam int POS_ADDR_LO  = 16;
	localparam int SYNC_STAGES  = 3;

	// ----------------------------------------
	// Register types
	// ----------------------------------------
	localparam logic [1:0] TYPE_CTRL   = 2'h0;
	localparam logic [1:0] TYPE_GAIN   = 2'h1;
	localparam logic [1:0] TYPE_OFFS   = 2'h2;
	localparam logic [1:0] TYPE_INPUT  = 2'h3;
	localparam logic [1:0] GTYPE_SYS   = 2'h0;
	localparam logic [1:0] GTYPE_CMP   = 2'h1;
	localparam logic [1:0] GTYPE_RSVD  = 2'h2;
	localparam logic [1:0] GTYPE_ALARM = 2'h3;

	// ----------------------------------------
	// Read request kinds
	// ----------------------------------------
	localparam logic [2:0] KIND_SYS    = 3'h0;
	localparam logic [2:0] KIND_CMP    = 3'h1;
	localparam logic [2:0] KIND_ALARM  = 3'h2;
	localparam logic [2:0] KIND_CHCTRL = 3'h3;
	localparam logic [2:0] KIND_DAC    = 3'h4;

	localparam logic [CMD_W-1:0] SHIFT_RESET = 29'h0000000;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_REQ  = 3'b010,
		ST_WAIT = 3'b100
	} pmurb_state_t;

endpackage

// ---- core/pmurb_readback.sv ----
`timescale 1ns/1ps
`default_nettype none
module pmurb_readback
	import pmurb_pkg::*;
(
	// System side
	input  wire logic              clk_sys_i,
	input  wire logic              reset_n_i,
	// Serial link
	input  wire logic              sclk_i,
	input  wire logic              sync_n_i,
	input  wire logic              sdi_i,
	output logic                   sdo_o,
	// Read request to register bank
	output logic                   rd_req_o,
	output logic [2:0]             rd_kind_o,
	output logic [3:0]             rd_channel_o,
	output logic [1:0]             rd_type_o,
	output logic [5:0]             rd_dac_addr_o,
	input  wire logic              rd_ack_i,
	input  wire logic [DATA_W-1:0] rd_data_i,
	// Commands that are not reads
	output logic                   wr_cmd_valid_o,
	output logic [CMD_W-1:0]       wr_cmd_o
);

	// ----------------------------------------
	// Link domain: shifting
	// ----------------------------------------
	logic [CMD_W-1:0]  shift_reg;
	logic [5:0]        bit_cnt_reg;
	logic              done_tgl_reg;
	logic [CMD_W-1:0]  cmd_hold_reg;
	logic              load_s1_reg, load_s2_reg, load_s3_reg;
	logic              load_seen_reg;
	logic [DATA_W-1:0] load_data_reg;
	logic              load_tgl_reg;

	// A new load counts once the second and third stages agree
	wire load_pend = (load_s2_reg == load_s3_reg) && (load_s3_reg != load_seen_reg);
	wire [CMD_W-1:0] shift_next = {shift_reg[CMD_W-2:0], sdi_i};

	// Sync low gates every shift; frame end captures the command
	always_ff @(posedge sclk_i or posedge sync_n_i) begin
		if (sync_n_i) begin
			bit_cnt_reg <= 6'h00;
		end else begin
			bit_cnt_reg <= (bit_cnt_reg == 6'h3F) ? bit_cnt_reg : bit_cnt_reg + 6'h01;
		end
	end

	// System reset clears the load synchronizer and shift register so the load toggle starts known
	always_ff @(posedge sclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			load_s1_reg   <= 1'b0;
			load_s2_reg   <= 1'b0;
			load_s3_reg   <= 1'b0;
			load_seen_reg <= 1'b0;
			shift_reg     <= SHIFT_RESET;
		end else begin
			load_s1_reg <= load_tgl_reg;
			load_s2_reg <= load_s1_reg;
			load_s3_reg <= load_s2_reg;
			if (sync_n_i && load_pend) begin
				shift_reg     <= {load_data_reg, {PAD_W{1'b0}}};
				load_seen_reg <= load_s3_reg;
			end else if (!sync_n_i) begin
				shift_reg <= shift_next;
			end
		end
	end

	// MSB is always on the output pin
	assign sdo_o = shift_reg[CMD_W-1];

	// Frame end after at least 24 bits: latch the shift register as the received command
	always_ff @(posedge sync_n_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			cmd_hold_reg <= SHIFT_RESET;
			done_tgl_reg <= 1'b0;
		end else if (bit_cnt_reg >= 6'(DATA_W)) begin
			cmd_hold_reg <= shift_reg;
			done_tgl_reg <= ~done_tgl_reg;
		end
	end

	// ----------------------------------------
	// System domain: decode
	// ----------------------------------------
	logic [SYNC_STAGES-1:0] done_sync_reg;
	logic                   done_seen_reg;
	logic [CMD_W-1:0]       cmd_reg;
	pmurb_state_t           state_reg, state_next;

	always_ff @(posedge clk_sys_i) begin
		done_sync_reg <= {done_sync_reg[SYNC_STAGES-2:0], done_tgl_reg};
	end

	// Second and third stages agree on a new level
	wire done_stable = done_sync_reg[1] == done_sync_reg[2];
	wire done_evt    = done_stable && (done_sync_reg[2] != done_seen_reg);

	wire       is_read  = cmd_hold_reg[POS_RW];
	wire [3:0] ch_sel   = cmd_hold_reg[POS_CH_HI:POS_CH_LO];
	wire [1:0] typ      = cmd_hold_reg[POS_TYPE_HI:POS_TYPE_LO];
	wire       ch_none  = ch_sel == 4'h0;
	wire       ch_one   = (ch_sel != 4'h0) && ((ch_sel & (ch_sel - 4'h1)) == 4'h0);

	function automatic logic [2:0] kind_of(input logic none, input logic [1:0] t);
		if (none) begin
			case (t)
				GTYPE_SYS:   kind_of = KIND_SYS;
				GTYPE_CMP:   kind_of = KIND_CMP;
				default:     kind_of = KIND_ALARM;
			endcase
		end else begin
			kind_of = (t == TYPE_CTRL) ? KIND_CHCTRL : KIND_DAC;
		end
	endfunction

	// Reserved global type and multi-channel selections are dropped
	wire valid_read = is_read && ((ch_none && typ != GTYPE_RSVD) || ch_one);

	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			ST_IDLE: if (done_evt && valid_read) state_next = ST_REQ;
			ST_REQ:  if (rd_ack_i) state_next = ST_WAIT;
			ST_WAIT: state_next = ST_IDLE;
		endcase
	end

	always_ff @(posedge clk_sys_i) begin
		if (!reset_n_i) begin
			state_reg      <= ST_IDLE;
			done_seen_reg  <= 1'b0;
			cmd_reg        <= SHIFT_RESET;
			load_tgl_reg   <= 1'b0;
			load_data_reg  <= '0;
			wr_cmd_valid_o <= 1'b0;
		end else begin
			state_reg      <= state_next;
			wr_cmd_valid_o <= done_evt && !is_read;
			if (done_evt) begin
				done_seen_reg <= done_sync_reg[2];
				cmd_reg       <= cmd_hold_reg;
			end
			if (state_reg == ST_REQ && rd_ack_i) begin
				load_data_reg <= rd_data_i;
				load_tgl_reg  <= ~load_tgl_reg;
			end
		end
	end

	assign wr_cmd_o      = cmd_reg;
	assign rd_req_o      = state_reg == ST_REQ;
	assign rd_channel_o  = cmd_reg[POS_CH_HI:POS_CH_LO];
	assign rd_type_o     = cmd_reg[POS_TYPE_HI:POS_TYPE_LO];
	assign rd_dac_addr_o = cmd_reg[POS_ADDR_HI:POS_ADDR_LO];
	assign rd_kind_o     = kind_of(cmd_reg[POS_CH_HI:POS_CH_LO] == 4'h0,
		cmd_reg[POS_TYPE_HI:POS_TYPE_LO]);

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	sequence s_ack;
		rd_req_o && rd_ack_i;
	endsequence

	AST_REQ_HOLDS: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
		rd_req_o && !rd_ack_i |=> rd_req_o)
		else $error("read request dropped before ack");
	AST_ACK_TOGGLES: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
		s_ack |=> load_tgl_reg != $past(load_tgl_reg) && load_data_reg == $past(rd_data_i))
		else $error("ack did not hand data to link");
	AST_NO_WRITE_READ: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
		$rose(rd_req_o) |-> cmd_reg[POS_RW])
		else $error("request raised for a non-read command");
	AST_RSVD_DROP: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
		rd_req_o |-> !(rd_channel_o == 4'h0 && rd_type_o == GTYPE_RSVD))
		else $error("reserved global type requested");
	AST_ONEHOT: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
		rd_req_o |-> $countones(rd_channel_o) <= 1)
		else $error("more than one channel selected");
	AST_KIND_DAC: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
		rd_req_o && rd_channel_o != 4'h0 && rd_type_o != TYPE_CTRL |-> rd_kind_o == KIND_DAC)
		else $error("channel DAC read mis-decoded");
	AST_KIND_SYS: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
		rd_req_o && rd_channel_o == 4'h0 && rd_type_o == GTYPE_SYS |-> rd_kind_o == KIND_SYS)
		else $error("system read mis-decoded");
	AST_MSB_OUT: assert property (@(posedge sclk_i) disable iff (!reset_n_i)
		!sync_n_i |=> sdo_o == $past(shift_reg[CMD_W-2]))
		else $error("output did not advance to the next bit");
	AST_SHIFT: assert property (@(posedge sclk_i) disable iff (!reset_n_i)
		!sync_n_i |=> shift_reg[CMD_W-1:1] == $past(shift_reg[CMD_W-2:0]))
		else $error("shift did not advance");

endmodule
`default_nettype wire

// ---- test/pmurb_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module pmurb_host_model (
	// Serial link, host side
	output logic      sclk_o,
	output logic      sync_n_o,
	output logic      sdi_o,
	input  wire logic sdo_i
);
	initial begin
		sclk_o = 1'b0;
		sync_n_o = 1'b1;
		sdi_o = 1'b0;
	end
	// ----------------------------------------
	// Framed transfer, MSB first
	// ----------------------------------------
	task automatic frame(input logic [28:0] word, input int n, output logic [28:0] got);
		got = '0;
		sync_n_o = 1'b0;
		for (int i = n - 1; i >= 0; i--) begin
			sdi_o = word[i];
			#3;
			got = {got[27:0], sdo_i};
			sclk_o = 1'b1;
			#3;
			sclk_o = 1'b0;
		end
		#3;
		sync_n_o = 1'b1;
		sdi_o = ~sdi_o;
	endtask
	// Free clocks with the frame idle, so the readback can load
	task automatic idle(input int n);
		repeat (n) begin
			#3 sclk_o = 1'b1;
			#3 sclk_o = 1'b0;
		end
	endtask
endmodule
`default_nettype wire

// ---- test/pmurb_readback_bench.sv ----
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin n_mismatch++; \
	$display("[ERR] t=%0t got=%0h exp=%0h", $time, (g), (e)); end end
module pmurb_readback_bench;
	import pmurb_pkg::*;
	logic              clk_sys_i = 1'b0;
	logic              reset_n_i;
	logic              rd_ack_i = 1'b0;
	logic [DATA_W-1:0] rd_data_i = '0;
	logic [DATA_W-1:0] bank_data = '0;
	wire logic         sclk, sync_n, sdi, sdo, rd_req, wr_valid;
	wire logic [2:0]   rd_kind;
	wire logic [3:0]   rd_ch;
	wire logic [1:0]   rd_type;
	wire logic [5:0]   rd_addr;
	wire logic [28:0]  wr_cmd;
	logic [28:0]       got, last_wr;
	logic [2:0]        kind_q;
	logic [3:0]        ch_q;
	logic [1:0]        type_q;
	logic [5:0]        addr_q;
	int                n_mismatch = 0, compares = 0, n_req = 0;

	always #2 clk_sys_i = ~clk_sys_i;
	pmurb_readback pmurb_readback_inst (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i),
		.sclk_i(sclk), .sync_n_i(sync_n), .sdi_i(sdi), .sdo_o(sdo), .rd_req_o(rd_req),
		.rd_kind_o(rd_kind), .rd_channel_o(rd_ch), .rd_type_o(rd_type),
		.rd_dac_addr_o(rd_addr), .rd_ack_i(rd_ack_i), .rd_data_i(rd_data_i),
		.wr_cmd_valid_o(wr_valid), .wr_cmd_o(wr_cmd));
	pmurb_host_model pmurb_host_model_inst (.sclk_o(sclk), .sync_n_o(sync_n), .sdi_o(sdi),
		.sdo_i(sdo));

	// ----------------------------------------
	// Register bank answer and write monitor
	// ----------------------------------------
	always @(posedge clk_sys_i) begin
		#1;
		rd_ack_i = (rd_req === 1'b1) && !rd_ack_i;
		rd_data_i = bank_data;
		if (rd_ack_i) begin
			n_req++;
			{kind_q, ch_q, type_q, addr_q} = {rd_kind, rd_ch, rd_type, rd_addr};
		end
		if (wr_valid === 1'b1) last_wr = wr_cmd;
	end

	// Read command, free clocks, then readback frame of n bits
	task automatic xfer(input logic [28:0] cmd, input int n, input logic [28:0] flush,
		input logic [23:0] d);
		int r0;
		r0 = n_req;
		bank_data = d;
		pmurb_host_model_inst.frame(cmd, 29, got);
		repeat (60) if (n_req == r0) @(posedge clk_sys_i);
		pmurb_host_model_inst.idle(8);
		pmurb_host_model_inst.frame(flush, n, got);
		repeat (60) @(posedge clk_sys_i);
	endtask

	task automatic t_sys();
		int r0;
		r0 = n_req;
		xfer({1'b1, 4'h0, GTYPE_SYS, 22'h0}, 24, 29'h0FFFFFF, 24'h3A5C1E);
		`CHK(n_req, r0 + 1)
		`CHK(kind_q, KIND_SYS)
		`CHK(got[23:0], 24'h3A5C1E)
		`CHK(last_wr, 29'h00FFFFFF)
		$display("test sys done");
	endtask

	task automatic t_glob();
		int r0;
		for (int t = 1; t < 4; t++) begin
			r0 = n_req;
			xfer({1'b1, 4'h0, 2'(t), 22'h0}, 24, 29'h0FFFFFF, 24'h5A5A5A);
			`CHK(n_req, r0 + (t == 2 ? 0 : 1))
			if (t != 2) `CHK(kind_q, (t == 1) ? KIND_CMP : KIND_ALARM)
		end
		$display("test glob done");
	endtask

	task automatic t_chan();
		int r0;
		logic [23:0] d;
		for (int c = 0; c < 4; c++) for (int t = 0; t < 4; t++) begin
			r0 = n_req;
			d = 24'hC35A96 ^ 24'(c * 16 + t);
			xfer({1'b1, 4'(1 << c), 2'(t), 6'(9 * c + t + 8), 16'h0}, 29, 29'h1FFFFFFF, d);
			`CHK(got, {d, 5'h00})
			`CHK(n_req, r0 + 1)
			`CHK(kind_q, (t == 0) ? KIND_CHCTRL : KIND_DAC)
			`CHK({ch_q, type_q}, {4'(1 << c), 2'(t)})
			if (t != 0) `CHK(addr_q, 6'(9 * c + t + 8))
		end
		$display("test chan done");
	endtask

	task automatic complete_run();
		$display("compares=%0d mismatches=%0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask

	initial begin
		#1 reset_n_i = 1'b0;
		repeat (4) @(posedge clk_sys_i);
		#1 reset_n_i = 1'b1;
		t_sys();
		t_glob();
		t_chan();
		complete_run();
	end
	initial begin
		#100000;
		n_mismatch++;
		complete_run();
	end
endmodule
`default_nettype wire
